// ===== core/cabe_defines.vh
`ifndef CABE_DEFINES_VH
`define CABE_DEFINES_VH
// Wishbone register byte offsets
`define CABE_REG_CTRL 8'h00
`define CABE_REG_INSTR 8'h04
`define CABE_REG_ACC 8'h08
`define CABE_REG_STATUS 8'h0c
`define CABE_REG_PC 8'h10
`define CABE_REG_FADDR 8'h14
`define CABE_REG_FDATA 8'h18
// Status field positions
`define CABE_ST_CARRY 0
`define CABE_ST_DC 1
`define CABE_ST_ZERO 2
`define CABE_ST_BUSY 3
// Control fields
`define CABE_CTRL_GO 0
// Opcode patterns, 14-bit instruction word
`define CABE_OP_ADDF 6'h07
`define CABE_OP_ADDC 6'h3d
`define CABE_OP_ASR 6'h37
`define CABE_OP4_BCLR 4'h4
`define CABE_OP4_BTSZ 4'h6
`define CABE_OP5_BRL 5'h19
`define CABE_OP_BRACC 14'h000b
`define CABE_OP_NOP 14'h0000
// Reset values
`define CABE_PC_RST 15'h0000
`define CABE_INSTR_RST 14'h0000
`endif

// ===== core/cabe_file_mem.v
`timescale 1ns/1ps
// 128 x 8 data-memory file, registered read
module cabe_file_mem (
   // Clock
   input wire clk,
   // Write port
   input wire wr_en,
   input wire [6:0] wr_addr,
   input wire [7:0] wr_data,
   // Read port
   input wire [6:0] rd_addr,
   output reg [7:0] rd_data
);
   reg [7:0] mem [0:127];
   always @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule // cabe_file_mem

// ===== core/cabe_alu.v
`timescale 1ns/1ps
`include "cabe_defines.vh"
// Combinational 8-bit datapath for add, add with carry and shift
module cabe_alu (
   // Operands
   input wire [7:0] acc,
   input wire [7:0] fval,
   input wire carry_in,
   input wire use_carry,
   input wire do_shift,
   // Results
   output reg [7:0] result,
   output reg carry_out,
   output reg dc_out,
   output reg zero_out
);
   reg [8:0] sum;
   reg [4:0] low;
   always @* begin
      sum = {1'b0, acc} + {1'b0, fval} + {8'h00, use_carry & carry_in};
      low = {1'b0, acc[3:0]} + {1'b0, fval[3:0]} + {4'h0, use_carry & carry_in};
      if (do_shift) begin
         result = {fval[7], fval[7:1]};
         carry_out = fval[0];
         dc_out = 1'b0;
      end else begin
         result = sum[7:0];
         carry_out = sum[8];
         dc_out = low[4];
      end
      zero_out = (result == 8'h00);
   end
endmodule // cabe_alu

// ===== core/cabe_core.v
`timescale 1ns/1ps
`include "cabe_defines.vh"
module cabe_core (
   // Clock and reset
   input wire clk,
   input wire resetn,
   // Wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // Core state
   output reg [14:0] pc_o,
   output reg busy_o
);
   localparam ST_IDLE = 2'b00;
   localparam ST_READ = 2'b01;
   localparam ST_EXEC = 2'b10;
   localparam ST_NOP = 2'b11;

   reg [1:0] state_ff, nxt_state;
   reg [13:0] instr_ff, nxt_instr;
   reg [13:0] next_instr_ff, nxt_next_instr;
   reg [7:0] acc_ff, nxt_acc;
   reg carry_ff, nxt_carry;
   reg dc_ff, nxt_dc;
   reg zero_ff, nxt_zero;
   reg [14:0] pc_ff, nxt_pc;
   reg [6:0] faddr_ff, nxt_faddr;
   reg ack_ff, nxt_ack;
   reg [31:0] rdat_ff, nxt_rdat;
   reg mem_we;
   reg [7:0] mem_wdata;
   reg [6:0] mem_waddr;
   reg [6:0] mem_raddr;
   reg [31:0] merged;
   wire [7:0] fval;
   wire [7:0] alu_res;
   wire alu_c;
   wire alu_dc;
   wire alu_z;
   wire bus_req;
   wire [6:0] op_f;
   wire op_d;
   wire [2:0] op_b;
   reg is_add, is_addc, is_asr, is_bclr, is_btsz, is_brl, is_bracc;

   assign bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
   assign op_f = instr_ff[6:0];
   assign op_d = instr_ff[7];
   assign op_b = instr_ff[9:7];

   // Replace each byte lane of a word whose select bit is set
   function [31:0] lane_merge;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0] sel;
      integer i;
      begin
         lane_merge = old_v;
         for (i = 0; i < 4; i = i + 1) begin
            if (sel[i]) begin
               lane_merge[i*8 +: 8] = new_v[i*8 +: 8];
            end
         end
      end
   endfunction

   always @* begin
      is_add = (instr_ff[13:8] == `CABE_OP_ADDF);
      is_addc = (instr_ff[13:8] == `CABE_OP_ADDC);
      is_asr = (instr_ff[13:8] == `CABE_OP_ASR);
      is_bclr = (instr_ff[13:10] == `CABE_OP4_BCLR);
      is_btsz = (instr_ff[13:10] == `CABE_OP4_BTSZ);
      is_brl = (instr_ff[13:9] == `CABE_OP5_BRL);
      is_bracc = (instr_ff == `CABE_OP_BRACC);
   end

   cabe_file_mem u_mem (
      .clk(clk),
      .wr_en(mem_we),
      .wr_addr(mem_waddr),
      .wr_data(mem_wdata),
      .rd_addr(mem_raddr),
      .rd_data(fval)
   );

   cabe_alu u_alu (
      .acc(acc_ff),
      .fval(fval),
      .carry_in(carry_ff),
      .use_carry(is_addc),
      .do_shift(is_asr),
      .result(alu_res),
      .carry_out(alu_c),
      .dc_out(alu_dc),
      .zero_out(alu_z)
   );

   always @* begin
      nxt_state = state_ff;
      nxt_instr = instr_ff;
      nxt_next_instr = next_instr_ff;
      nxt_acc = acc_ff;
      nxt_carry = carry_ff;
      nxt_dc = dc_ff;
      nxt_zero = zero_ff;
      nxt_pc = pc_ff;
      nxt_faddr = faddr_ff;
      nxt_ack = 1'b0;
      merged = 32'h0000_0000;
      nxt_rdat = 32'h0000_0000;
      mem_we = 1'b0;
      mem_waddr = op_f;
      mem_wdata = alu_res;
      mem_raddr = (state_ff == ST_IDLE) ? faddr_ff : op_f;
      // Bus only served while idle, so software never races the datapath
      if (bus_req && (state_ff == ST_IDLE)) begin
         nxt_ack = 1'b1;
         case (wb_adr_i)
            `CABE_REG_CTRL: begin
               if (wb_we_i && wb_sel_i[0] && wb_dat_i[`CABE_CTRL_GO]) begin
                  nxt_state = ST_READ;
               end
            end
            `CABE_REG_INSTR: begin
               if (wb_we_i) begin
                  merged = lane_merge({18'h00000, instr_ff}, wb_dat_i, wb_sel_i);
                  nxt_next_instr = merged[13:0];
                  nxt_instr = merged[13:0];
               end
               nxt_rdat = {18'h00000, instr_ff};
            end
            `CABE_REG_ACC: begin
               if (wb_we_i && wb_sel_i[0]) begin
                  nxt_acc = wb_dat_i[7:0];
               end
               nxt_rdat = {24'h000000, acc_ff};
            end
            `CABE_REG_STATUS: begin
               if (wb_we_i && wb_sel_i[0]) begin
                  nxt_carry = wb_dat_i[`CABE_ST_CARRY];
                  nxt_dc = wb_dat_i[`CABE_ST_DC];
                  nxt_zero = wb_dat_i[`CABE_ST_ZERO];
               end
               nxt_rdat = {29'h00000000, zero_ff, dc_ff, carry_ff};
            end
            `CABE_REG_PC: begin
               if (wb_we_i) begin
                  merged = lane_merge({17'h00000, pc_ff}, wb_dat_i, wb_sel_i);
                  nxt_pc = merged[14:0];
               end
               nxt_rdat = {17'h00000, pc_ff};
            end
            `CABE_REG_FADDR: begin
               if (wb_we_i && wb_sel_i[0]) begin
                  nxt_faddr = wb_dat_i[6:0];
               end
               nxt_rdat = {25'h0000000, faddr_ff};
            end
            `CABE_REG_FDATA: begin
               if (wb_we_i && wb_sel_i[0]) begin
                  mem_we = 1'b1;
                  mem_waddr = faddr_ff;
                  mem_wdata = wb_dat_i[7:0];
               end
               nxt_rdat = {24'h000000, fval};
            end
            default: begin
               nxt_rdat = 32'h0000_0000;
            end
         endcase
      end else begin
         case (state_ff)
            ST_IDLE: begin
               nxt_state = ST_IDLE;
            end
            ST_READ: begin
               // File operand arrives registered one cycle later
               nxt_state = ST_EXEC;
            end
            ST_EXEC: begin
               nxt_pc = pc_ff + 15'h0001;
               nxt_state = ST_IDLE;
               if (is_add || is_addc) begin
                  nxt_carry = alu_c;
                  nxt_dc = alu_dc;
                  nxt_zero = alu_z;
               end
               if (is_asr) begin
                  nxt_carry = alu_c;
                  nxt_zero = alu_z;
               end
               if (is_add || is_addc || is_asr) begin
                  if (op_d) begin
                     mem_we = 1'b1;
                  end else begin
                     nxt_acc = alu_res;
                  end
               end
               if (is_bclr) begin
                  mem_we = 1'b1;
                  mem_wdata = fval & ~(8'h01 << op_b);
               end
               if (is_btsz && !fval[op_b]) begin
                  nxt_state = ST_NOP;
                  nxt_pc = pc_ff + 15'h0002;
               end
               if (is_brl) begin
                  nxt_pc = pc_ff + 15'h0001 + {{6{instr_ff[8]}}, instr_ff[8:0]};
                  nxt_state = ST_NOP;
               end
               if (is_bracc) begin
                  nxt_pc = pc_ff + 15'h0001 + {7'h00, acc_ff};
                  nxt_state = ST_NOP;
               end
            end
            ST_NOP: begin
               // Instruction word reloaded from next_instr_ff; this cycle does nothing else
               nxt_instr = `CABE_OP_NOP;
               nxt_state = ST_IDLE;
            end
            default: begin
               nxt_state = ST_IDLE;
            end
         endcase
      end
      if (state_ff == ST_NOP && nxt_state == ST_IDLE) begin
         nxt_instr = next_instr_ff;
      end
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_ff <= ST_IDLE;
         instr_ff <= `CABE_INSTR_RST;
         next_instr_ff <= `CABE_INSTR_RST;
         acc_ff <= 8'h00;
         carry_ff <= 1'b0;
         dc_ff <= 1'b0;
         zero_ff <= 1'b0;
         pc_ff <= `CABE_PC_RST;
         faddr_ff <= 7'h00;
         ack_ff <= 1'b0;
         rdat_ff <= 32'h0000_0000;
         pc_o <= `CABE_PC_RST;
         busy_o <= 1'b0;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         state_ff <= nxt_state;
         instr_ff <= nxt_instr;
         next_instr_ff <= nxt_next_instr;
         acc_ff <= nxt_acc;
         carry_ff <= nxt_carry;
         dc_ff <= nxt_dc;
         zero_ff <= nxt_zero;
         pc_ff <= nxt_pc;
         faddr_ff <= nxt_faddr;
         ack_ff <= nxt_ack;
         rdat_ff <= nxt_rdat;
         pc_o <= nxt_pc;
         busy_o <= (nxt_state != ST_IDLE);
         wb_ack_o <= nxt_ack;
         wb_dat_o <= nxt_rdat;
      end
   end
endmodule // cabe_core

// ===== verification/cabe_prog_rom.sv
`timescale 1ns/1ps
// Program store feeding one instruction word per step
module cabe_prog_rom (
   // Step select
   input wire [3:0] idx,
   // Instruction word
   output logic [13:0] word
);
   always_comb begin
      case (idx)
         4'h0: word = 14'h07ff;
         4'h1: word = 14'h3d7f;
         4'h2: word = 14'h37ff;
         4'h3: word = 14'h13ff;
         4'h4: word = 14'h1b7f;
         4'h5: word = 14'h1bff;
         4'h6: word = 14'h3300;
         4'h7: word = 14'h32ff;
         4'h8: word = 14'h000b;
         default: word = 14'h0000;
      endcase
   end
endmodule // cabe_prog_rom

// ===== verification/cabe_core_asserts.sv
`timescale 1ns/1ps
module cabe_core_asserts (
   // Clock and reset
   input wire clk,
   input wire resetn,
   // Wishbone
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   // Core state
   input wire [14:0] pc_o,
   input wire busy_o
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence s_run2; busy_o ##1 busy_o; endsequence
   sequence s_run3; busy_o [*3]; endsequence
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   property p_ack_req; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
   a_ack_req: assert property (p_ack_req) else $error("ack without request");
   property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
   a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
   property p_busy_min; $rose(busy_o) |-> s_run2; endproperty
   a_busy_min: assert property (p_busy_min) else $error("instruction shorter than two cycles");
   property p_busy_max; s_run3 |=> !busy_o; endproperty
   a_busy_max: assert property (p_busy_max) else $error("instruction longer than three cycles");
   property p_busy_end; $rose(busy_o) |-> ##[2:3] !busy_o; endproperty
   a_busy_end: assert property (p_busy_end) else $error("instruction did not finish");
   property p_busy_cause; $rose(busy_o) |-> $past(wb_cyc_i && wb_we_i); endproperty
   a_busy_cause: assert property (p_busy_cause) else $error("start without a write");
   property p_no_ack_busy; busy_o && $past(busy_o) |-> !wb_ack_o; endproperty
   a_no_ack_busy: assert property (p_no_ack_busy) else $error("ack while executing");
endmodule // cabe_core_asserts
bind cabe_core cabe_core_asserts i_chk (.clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pc_o(pc_o), .busy_o(busy_o));

// ===== verification/cpu_alu_bit_branch_exec_tb.sv
`timescale 1ns/1ps
`include "cabe_defines.vh"
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin num_errors++; $display("unexpected %s exp %h got %h", nm, e, s); end end
module cpu_alu_bit_branch_exec_tb;
   logic clk = 0, resetn = 0, cyc = 0, stb = 0, we = 0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0, q, rdat;
   logic ack, busy;
   logic [14:0] pc;
   logic [3:0] idx = 4'h0;
   logic [13:0] word;
   int num_errors = 0, compares = 0, n, tick = 0;
   // Expected pc, busy cycles, flags, accumulator and file value after each step
   logic [14:0] e_pc [9] = '{15'h1, 15'h2, 15'h3, 15'h4, 15'h5, 15'h7, 15'h7f08, 15'h8, 15'h99};
   int e_cyc [9] = '{2, 2, 2, 2, 2, 3, 3, 3, 3};
   logic [3:0] e_st [9] = '{4'h7, 4'h2, 4'h3, 4'h3, 4'h3, 4'h3, 4'h3, 4'h3, 4'h3};
   logic [7:0] e_acc [9] = '{8'h8f, 8'h90, 8'h90, 8'h90, 8'h90, 8'h90, 8'h90, 8'h90, 8'h90};
   logic [7:0] e_f [9] = '{8'h00, 8'h00, 8'hc0, 8'h40, 8'h40, 8'h40, 8'h40, 8'h40, 8'h40};
   cabe_core i_dut (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .pc_o(pc), .busy_o(busy));
   cabe_prog_rom i_prog (.idx(idx), .word(word));
   initial begin
      forever #2.5 clk = ~clk;
   end
   task conclude;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Classic single cycle; request held until ack is sampled
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      @(posedge clk);
      while (ack !== 1'b1) @(posedge clk);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   always @(posedge clk) begin
      tick <= tick + 1;
      if (tick == 5000) begin
         num_errors++;
         conclude;
      end
   end
   initial begin
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      wb(0, `CABE_REG_PC, 0, q);
      `CHK("pc", 32'h0, q)
      wb(0, `CABE_REG_STATUS, 0, q);
      `CHK("status", 32'h0, q)
      wb(0, 8'h1c, 0, q);
      `CHK("unmapped", 32'h0, q)
      wb(1, `CABE_REG_ACC, 32'h8f, q);
      wb(1, `CABE_REG_FADDR, 32'h7f, q);
      wb(1, `CABE_REG_FDATA, 32'h71, q);
      for (int i = 0; i < 9; i++) begin
         // Shift step needs both end bits set to show sign keep and carry out
         if (i == 2) wb(1, `CABE_REG_FDATA, 32'h81, q);
         idx = i[3:0];
         #1;
         wb(1, `CABE_REG_INSTR, {18'h0, word}, q);
         wb(1, `CABE_REG_CTRL, 32'h1, q);
         // Busy was raised at the edge that gave ack, so counting starts here
         n = 0;
         while (busy === 1'b1 && n < 10) begin
            n++;
            @(posedge clk);
         end
         `CHK("cycles", e_cyc[i], n)
         wb(0, `CABE_REG_PC, 0, q);
         `CHK("pc", e_pc[i], q[14:0])
         `CHK("pc pin", e_pc[i], pc)
         wb(0, `CABE_REG_INSTR, 0, q);
         `CHK("instr", {18'h0, word}, q)
         wb(0, `CABE_REG_CTRL, 0, q);
         `CHK("ctrl", 32'h0, q)
         wb(0, `CABE_REG_STATUS, 0, q);
         `CHK("status", e_st[i], q[3:0])
         wb(0, `CABE_REG_ACC, 0, q);
         `CHK("acc", e_acc[i], q[7:0])
         wb(0, `CABE_REG_FDATA, 0, q);
         `CHK("file", e_f[i], q[7:0])
      end
      conclude;
   end
endmodule // cpu_alu_bit_branch_exec_tb
